// >>> ddr2_init_pkg.sv
// constants shared by the init controller and the mode register model
// assumes a 125 MHz system clock on both ends
package ddr2_init_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 8;
    localparam int unsigned T_STABLE_US     = 200;
    localparam int unsigned T_STABLE_CYC    =
        (T_STABLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned T_CKE_NS        = 400;
    localparam int unsigned T_CKE_CYC       =
        (T_CKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DLL_LOCK_CLK    = 200;
    localparam int unsigned TMRD_CLK        = 2;
    localparam int unsigned REFRESH_COUNT   = 2;
    localparam int unsigned LINK_DIV        = 4;
    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS          = 4'h0;
    localparam logic [3:0] CMD_REFRESH      = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE    = 4'h2;
    localparam logic [3:0] CMD_NOP          = 4'h7;
    localparam logic [3:0] CMD_DESELECT     = 4'hF;
    // bank selects for mode register writes
    localparam logic [1:0] BANK_MR          = 2'h0;
    localparam logic [1:0] BANK_EMR1        = 2'h1;
    localparam logic [1:0] BANK_EMR2        = 2'h2;
    localparam logic [1:0] BANK_EMR3        = 2'h3;
    // field positions
    localparam int unsigned MR_BL_LSB       = 0;
    localparam int unsigned MR_BT_BIT       = 3;
    localparam int unsigned MR_CL_LSB       = 4;
    localparam int unsigned MR_TM_BIT       = 7;
    localparam int unsigned MR_DLL_RST_BIT  = 8;
    localparam int unsigned MR_WR_LSB       = 9;
    localparam int unsigned EMR1_DLL_DIS    = 0;
    localparam int unsigned EMR1_DRV_BIT    = 1;
    localparam int unsigned EMR1_RTT0_BIT   = 2;
    localparam int unsigned EMR1_AL_LSB     = 3;
    localparam int unsigned EMR1_RTT1_BIT   = 6;
    localparam int unsigned EMR1_OCD_LSB    = 7;
    localparam int unsigned EMR1_DQSN_BIT   = 10;
    localparam int unsigned EMR2_DCC_BIT    = 3;
    localparam int unsigned EMR2_HTSR_BIT   = 7;
    localparam logic [2:0] OCD_EXIT         = 3'h0;
    localparam logic [2:0] OCD_DEFAULT      = 3'h7;
    localparam logic [2:0] BL_4             = 3'h2;
    localparam logic [2:0] BL_8             = 3'h3;
endpackage : ddr2_init_pkg

// >>> ddr2_cmd_if.sv
// command link between init controller and mode register model
// assumes both ends share clk_in; link clock is a pin sampled by the device
`timescale 1ns/1ns
interface ddr2_cmd_if;
    logic        ck;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] addr;
    modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
    modport dev  (input  ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : ddr2_cmd_if

// >>> ddr2_init_ctrl.sv
// controller end: power-up sequence and mode register programming
// assumes a plain register port driven by software on clk_in
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module ddr2_init_ctrl #(
    parameter int unsigned STABLE_CYC = ddr2_init_pkg::T_STABLE_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [1:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    ddr2_cmd_if.ctrl         link
);
    // register map: 0 control, 1 MR value, 2 EMR1 value, 3 status
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_MR   = 2'h1;
    localparam logic [1:0] REG_EMR1 = 2'h2;
    localparam logic [1:0] REG_STAT = 2'h3;

    typedef enum logic [3:0] {
        S_IDLE  = 4'h0, S_STABLE = 4'h1, S_CKE   = 4'h2, S_PRE1 = 4'h3,
        S_EMR2  = 4'h4, S_EMR3   = 4'h5, S_EMR1  = 4'h6, S_MRRST = 4'h7,
        S_PRE2  = 4'h8, S_REF    = 4'h9, S_MR    = 4'hA, S_LOCK = 4'hB,
        S_OCDD  = 4'hC, S_OCDX   = 4'hD, S_DONE  = 4'hE
    } state_t;

    state_t      state_r;
    logic        start_r;
    logic        skip_rst_r;
    logic [12:0] mr_r;
    logic [12:0] emr1_r;
    logic [17:0] cnt_r;
    logic [1:0]  ref_r;
    logic [8:0]  lock_r;
    logic [1:0]  div_r;
    logic        issue;
    logic [3:0]  cmd_nxt;
    logic [1:0]  ba_nxt;
    logic [12:0] a_nxt;

    // software registers
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            start_r    <= 1'b0;
            skip_rst_r <= 1'b0;
            mr_r       <= 13'h0032;
            emr1_r     <= 13'h0000;
        end else begin
            start_r <= wr_in && addr_in == REG_CTRL && wdata_in[0];
            if (wr_in && addr_in == REG_CTRL)
                skip_rst_r <= wdata_in[1];
            if (wr_in && addr_in == REG_MR)
                mr_r <= {wdata_in[12:9], wdata_in[8:7] & 2'h0,
                         wdata_in[6:0]};
            if (wr_in && addr_in == REG_EMR1)
                emr1_r <= {2'h0, wdata_in[10:0]};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in)
            rdata_out <= 16'h0000;
        else if (rd_in)
            case (addr_in)
                REG_CTRL: rdata_out <= {14'h0000, skip_rst_r, 1'b0};
                REG_MR:   rdata_out <= {3'h0, mr_r};
                REG_EMR1: rdata_out <= {3'h0, emr1_r};
                default:  rdata_out <= {11'h000, state_r == S_DONE,
                                        state_r};
            endcase
        else
            rdata_out <= 16'h0000;
    end

    // link clock by divider
    always_ff @(posedge clk_in) begin
        if (!reset_n_in)
            div_r <= 2'h0;
        else
            div_r <= div_r + 2'h1;
    end
    assign issue = div_r == 2'h3;

    // DLL lock counter from DLL enable / reset
    always_ff @(posedge clk_in) begin
        if (!reset_n_in)
            lock_r <= 9'h000;
        else if (issue && (state_r == S_EMR1 || state_r == S_MRRST))
            lock_r <= 9'(ddr2_init_pkg::DLL_LOCK_CLK);
        else if (issue && lock_r != 9'h000)
            lock_r <= lock_r - 9'h001;
    end

    always_comb begin
        cmd_nxt = ddr2_init_pkg::CMD_NOP;
        ba_nxt  = 2'h0;
        a_nxt   = 13'h0000;
        case (state_r)
            S_PRE1, S_PRE2: begin
                cmd_nxt = ddr2_init_pkg::CMD_PRECHARGE;
                a_nxt   = 13'h0400;
            end
            S_EMR2: begin
                cmd_nxt = ddr2_init_pkg::CMD_MRS;
                ba_nxt  = ddr2_init_pkg::BANK_EMR2;
            end
            S_EMR3: begin
                cmd_nxt = ddr2_init_pkg::CMD_MRS;
                ba_nxt  = ddr2_init_pkg::BANK_EMR3;
            end
            S_EMR1: begin
                cmd_nxt = ddr2_init_pkg::CMD_MRS;
                ba_nxt  = ddr2_init_pkg::BANK_EMR1;
                a_nxt   = emr1_r & 13'h1C7E;
            end
            S_MRRST: begin
                cmd_nxt = ddr2_init_pkg::CMD_MRS;
                a_nxt   = mr_r | 13'h0100;
            end
            S_REF:    cmd_nxt = ddr2_init_pkg::CMD_REFRESH;
            S_MR:     cmd_nxt = ddr2_init_pkg::CMD_MRS;
            S_OCDD, S_OCDX: begin
                cmd_nxt = ddr2_init_pkg::CMD_MRS;
                ba_nxt  = ddr2_init_pkg::BANK_EMR1;
                a_nxt   = {emr1_r[12:10],
                    state_r == S_OCDD ? ddr2_init_pkg::OCD_DEFAULT
                                      : ddr2_init_pkg::OCD_EXIT,
                    emr1_r[6:1], 1'b0};
            end
            default:  cmd_nxt = ddr2_init_pkg::CMD_NOP;
        endcase
        if (state_r == S_MR)
            a_nxt = mr_r & 13'h1EFF;
        if (state_r == S_IDLE || state_r == S_STABLE)
            cmd_nxt = ddr2_init_pkg::CMD_DESELECT;
    end

    // sequence; every step waits at least tMRD link cycles
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_r <= S_IDLE;
            cnt_r   <= 18'h00000;
            ref_r   <= 2'h0;
        end else if (state_r == S_IDLE) begin
            cnt_r <= 18'h00000;
            if (start_r) begin
                // stable wait runs with cke still low
                state_r <= S_STABLE;
                cnt_r   <= 18'(STABLE_CYC);
            end
        end else if (cnt_r != 18'h00000) begin
            cnt_r <= cnt_r - 18'h00001;
        end else if (issue) begin
            cnt_r <= 18'(ddr2_init_pkg::TMRD_CLK * ddr2_init_pkg::LINK_DIV);
            case (state_r)
                S_STABLE: state_r <= S_CKE;
                S_CKE: begin
                    state_r <= S_PRE1;
                    cnt_r   <= 18'(ddr2_init_pkg::T_CKE_CYC);
                end
                S_PRE1:  state_r <= S_EMR2;
                S_EMR2:  state_r <= S_EMR3;
                S_EMR3:  state_r <= S_EMR1;
                S_EMR1:  state_r <= skip_rst_r ? S_PRE2 : S_MRRST;
                S_MRRST: state_r <= S_PRE2;
                S_PRE2:  state_r <= S_REF;
                S_REF: begin
                    ref_r <= ref_r + 2'h1;
                    if (ref_r == 2'(ddr2_init_pkg::REFRESH_COUNT - 1))
                        state_r <= S_MR;
                end
                S_MR:    state_r <= S_LOCK;
                S_LOCK:  if (lock_r == 9'h000)
                             state_r <= S_OCDD;
                S_OCDD:  state_r <= S_OCDX;
                S_OCDX:  state_r <= S_DONE;
                S_DONE:  state_r <= S_DONE;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // link pins, changed one clk_in cycle after the rising link clock edge
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            link.ck    <= 1'b0;
            link.cke   <= 1'b0;
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hF;
            link.ba    <= 2'h0;
            link.addr  <= 13'h0000;
        end else begin
            link.ck <= div_r[1];
            if (div_r == 2'h3) begin
                link.cke <= state_r != S_IDLE && state_r != S_STABLE;
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <=
                    (cnt_r == 18'h00000) ? cmd_nxt
                                         : ddr2_init_pkg::CMD_NOP;
                link.ba   <= ba_nxt;
                link.addr <= a_nxt;
            end
        end
    end
endmodule : ddr2_init_ctrl

// >>> ddr2_mode_regs.sv
// device end: decodes mode register writes and exposes their fields
// assumes link pins arrive asynchronously and are synchronised here
`timescale 1ns/1ns
module ddr2_mode_regs (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    ddr2_cmd_if.dev          link,
    input  wire logic [2:0]  col_start_in,
    input  wire logic [2:0]  beat_in,
    output logic [2:0]       col_out,
    output logic [12:0]      mr_out,
    output logic [12:0]      emr1_out,
    output logic [12:0]      emr2_out,
    output logic [3:0]       written_out,
    output logic [2:0]       cas_lat_out,
    output logic             dll_on_out,
    output logic             dqs_n_en_out,
    output logic             read_ok_out
);
    logic [20:0] s1_r;
    logic [20:0] s2_r;
    logic        ck_d_r;
    logic [12:0] mr_r;
    logic [12:0] emr1_r;
    logic [12:0] emr2_r;
    logic [8:0]  lock_r;
    logic        take;
    logic [2:0]  col_nxt;

    // two-flop sync of all link pins
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s1_r   <= 21'h000000;
            s2_r   <= 21'h000000;
            ck_d_r <= 1'b0;
        end else begin
            s1_r   <= {link.ck, link.cke, link.cs_n, link.ras_n,
                       link.cas_n, link.we_n, link.ba, link.addr};
            s2_r   <= s1_r;
            ck_d_r <= s2_r[20];
        end
    end

    // rising link edge, CKE high, all command pins low
    assign take = s2_r[20] && !ck_d_r && s2_r[19] &&
                  s2_r[18:15] == ddr2_init_pkg::CMD_MRS;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            mr_r        <= 13'h0000;
            emr1_r      <= 13'h0000;
            emr2_r      <= 13'h0000;
            written_out <= 4'h0;
        end else if (take) begin
            written_out[s2_r[14:13]] <= 1'b1;
            case (s2_r[14:13])
                ddr2_init_pkg::BANK_MR:   mr_r   <= s2_r[12:0];
                ddr2_init_pkg::BANK_EMR1: emr1_r <= s2_r[12:0];
                ddr2_init_pkg::BANK_EMR2: emr2_r <= s2_r[12:0];
                default:                  emr2_r <= emr2_r;
            endcase
        end
    end

    // lock restarts on dll turn-on or reset, not on emr1 rewrites
    always_ff @(posedge clk_in) begin
        if (!reset_n_in)
            lock_r <= 9'(ddr2_init_pkg::DLL_LOCK_CLK);
        else if (take && ((s2_r[14:13] == ddr2_init_pkg::BANK_EMR1 &&
                 !s2_r[ddr2_init_pkg::EMR1_DLL_DIS] &&
                 (!written_out[1] || emr1_r[ddr2_init_pkg::EMR1_DLL_DIS])) ||
                 (s2_r[14:13] == ddr2_init_pkg::BANK_MR &&
                 s2_r[ddr2_init_pkg::MR_DLL_RST_BIT])))
            lock_r <= 9'(ddr2_init_pkg::DLL_LOCK_CLK);
        else if (s2_r[20] && !ck_d_r && lock_r != 9'h000)
            lock_r <= lock_r - 9'h001;
    end

    // burst column ordering
    always_comb begin
        col_nxt = col_start_in ^ beat_in;
        if (!mr_r[ddr2_init_pkg::MR_BT_BIT]) begin
            col_nxt[1:0] = 2'(col_start_in[1:0] + beat_in[1:0]);
            col_nxt[2]   = col_start_in[2] ^ beat_in[2];
        end
        if (mr_r[2:0] == ddr2_init_pkg::BL_4)
            col_nxt[2] = col_start_in[2];
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            col_out      <= 3'h0;
            mr_out       <= 13'h0000;
            emr1_out     <= 13'h0000;
            emr2_out     <= 13'h0000;
            cas_lat_out  <= 3'h0;
            dll_on_out   <= 1'b0;
            dqs_n_en_out <= 1'b0;
            read_ok_out  <= 1'b0;
        end else begin
            col_out      <= col_nxt;
            mr_out       <= mr_r;
            emr1_out     <= emr1_r;
            emr2_out     <= emr2_r;
            cas_lat_out  <= mr_r[6:4];
            dll_on_out   <= !emr1_r[ddr2_init_pkg::EMR1_DLL_DIS];
            dqs_n_en_out <= !emr1_r[ddr2_init_pkg::EMR1_DQSN_BIT];
            read_ok_out  <= lock_r == 9'h000 && &written_out;
        end
    end
endmodule : ddr2_mode_regs

// >>> ddr2_init_sva.sv
// checker for the command link between controller and mode registers
// assumes every link signal is launched from the clk_in domain
`timescale 1ns/1ns
module ddr2_init_sva (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic        ck,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  ba,
    input wire logic [12:0] addr
);
    localparam int unsigned QUIET = ddr2_init_pkg::T_CKE_CYC;
    logic [3:0]  cmd;
    logic        idle;
    logic        mrs;
    logic        first_r;
    int unsigned quiet_r;
    assign cmd  = {cs_n, ras_n, cas_n, we_n};
    assign idle = cs_n || cmd == ddr2_init_pkg::CMD_NOP;
    assign mrs  = cmd == ddr2_init_pkg::CMD_MRS;
    // cycles since cke went high, saturating
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || !cke)
            quiet_r <= 0;
        else if (quiet_r < QUIET)
            quiet_r <= quiet_r + 1;
    end
    // set once the first real command is sampled
    always_ff @(posedge clk_in) begin
        if (!reset_n_in)
            first_r <= 1'b0;
        else if ($rose(ck) && cke && !idle)
            first_r <= 1'b1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence mrs_end;
        mrs ##1 !mrs;
    endsequence
    sequence ocd_default_end;
        (mrs && ba == ddr2_init_pkg::BANK_EMR1 &&
         addr[9:7] == ddr2_init_pkg::OCD_DEFAULT) ##1 !mrs;
    endsequence
    a_ck_divide: assert property (
        $rose(ck) |=> ck ##1 !ck [*2] ##1 ck)
        else $error("link clock not a divide by four");
    a_cmd_steady: assert property (
        $rose(ck) |-> $stable({cke, cmd, ba, addr}))
        else $error("command pins move at link clock rise");
    a_cke_on_nop: assert property ($rose(cke) |-> idle)
        else $error("cke raised without nop or deselect");
    a_quiet_after_cke: assert property (
        $rose(ck) && cke && quiet_r < QUIET |-> idle)
        else $error("command within 400 ns of cke rise");
    a_first_prech: assert property (
        $rose(ck) && cke && !idle && !first_r |->
        cmd == ddr2_init_pkg::CMD_PRECHARGE && addr[10])
        else $error("first command not precharge all");
    a_mrs_cke: assert property (mrs |-> cke)
        else $error("mode write with cke low");
    a_mrd_gap: assert property (mrs_end |-> idle [*8])
        else $error("mode write gap too short");
    a_emr1_fields: assert property (
        mrs && ba == ddr2_init_pkg::BANK_EMR1 |-> !addr[0] && !addr[11])
        else $error("emr1 with dll off or a11 set");
    a_emr2_reserved: assert property (
        mrs && ba == ddr2_init_pkg::BANK_EMR2 |->
        addr[2:0] == 3'h0 && addr[6:4] == 3'h0 && addr[12:8] == 5'h00)
        else $error("emr2 reserved bits set");
    a_emr3_zero: assert property (
        mrs && ba == ddr2_init_pkg::BANK_EMR3 |-> addr == 13'h0000)
        else $error("emr3 not zero");
    a_mr_no_test: assert property (
        mrs && ba == ddr2_init_pkg::BANK_MR |-> !addr[7])
        else $error("mode register test mode set");
    a_ocd_exit: assert property (
        ocd_default_end |-> ##[8:16] (mrs &&
        ba == ddr2_init_pkg::BANK_EMR1 &&
        addr[9:7] == ddr2_init_pkg::OCD_EXIT))
        else $error("no ocd exit after ocd default");
endmodule : ddr2_init_sva

// >>> ddr2_init_mode_registers_bench.sv
// bench: controller and mode registers joined by the link, plus a
// second mode register end driven directly by the bench
// assumes package, interface and both design ends compiled first
`timescale 1ns/1ns
module ddr2_init_mode_registers_bench;
    localparam int unsigned STABLE = 20;
    localparam int          LOCK   = 4 * ddr2_init_pkg::DLL_LOCK_CLK;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [1:0]  addr_in = 2'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [2:0]  col_start_in = 3'h0;
    logic [2:0]  beat_in = 3'h0;
    logic [15:0] rdata_out;
    logic [2:0]  col_out, cas_lat_out, b_col;
    logic [12:0] mr_out, emr1_out, emr2_out, b_emr2;
    logic [3:0]  written_out, b_written;
    logic        dll_on_out, dqs_n_en_out, read_ok_out;
    logic        ck_q = 1'b0;
    logic        cke_q = 1'b0;
    int          go_cnt = -1;
    int          cke_at = 0;
    logic        early = 1'b0;
    int          dll_cnt = -1;
    int          err_total = 0;
    int          checked = 0;
    logic [18:0] seen_q[$];
    ddr2_cmd_if link ();
    ddr2_cmd_if link_b ();
    ddr2_init_ctrl #(.STABLE_CYC(STABLE)) u_ddr2_init_ctrl (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .link(link.ctrl));
    ddr2_mode_regs u_ddr2_mode_regs (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .link(link.dev),
        .col_start_in(col_start_in), .beat_in(beat_in), .col_out(col_out),
        .mr_out(mr_out), .emr1_out(emr1_out), .emr2_out(emr2_out),
        .written_out(written_out), .cas_lat_out(cas_lat_out),
        .dll_on_out(dll_on_out), .dqs_n_en_out(dqs_n_en_out),
        .read_ok_out(read_ok_out));
    ddr2_mode_regs u_ddr2_mode_regs_b (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .link(link_b.dev),
        .col_start_in(col_start_in), .beat_in(beat_in), .col_out(b_col),
        .mr_out(), .emr1_out(), .emr2_out(b_emr2),
        .written_out(b_written), .cas_lat_out(), .dll_on_out(),
        .dqs_n_en_out(), .read_ok_out());
    ddr2_init_sva u_ddr2_init_sva (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .ck(link.ck),
        .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
        .addr(link.addr));
    always #4 clk_in = ~clk_in;
    // log sampled commands and time since dll enable
    always @(posedge clk_in) begin
        ck_q  <= link.ck;
        cke_q <= link.cke;
        if (wr_in && addr_in == 2'h0 && wdata_in[0])
            go_cnt <= 0;
        else if (go_cnt >= 0)
            go_cnt <= go_cnt + 1;
        if (link.cke && !cke_q)
            cke_at <= go_cnt;
        if (!reset_n_in) begin
            dll_cnt <= -1;
            early   <= 1'b0;
            seen_q.delete();
        end else if (dll_cnt >= 0)
            dll_cnt <= dll_cnt + 1;
        if (read_ok_out === 1'b1 && dll_cnt < LOCK)
            early <= 1'b1;
        if (link.ck && !ck_q && link.cke && !link.cs_n &&
            {link.ras_n, link.cas_n, link.we_n} != 3'h7) begin
            seen_q.push_back({link.cs_n, link.ras_n, link.cas_n,
                              link.we_n, link.ba, link.addr});
            if ({link.ras_n, link.cas_n, link.we_n, link.ba} == 5'h01 &&
                dll_cnt < 0)
                dll_cnt <= 0;
        end
    end
    task automatic check(input string what, input logic [18:0] seen,
                         input logic [18:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 d = rdata_out;
    endtask : rd
    function automatic logic [18:0] mk(input logic [3:0] c,
                                       input logic [1:0] b,
                                       input logic [12:0] a);
        return {c, b, a};
    endfunction : mk
    task automatic run_init(input logic skip, input logic [12:0] mr,
                            input logic [12:0] e1);
        logic [18:0] exp_q[$];
        logic [18:0] s;
        logic [15:0] d;
        int          n;
        wr(2'h1, {3'h0, mr} | 16'h0180);
        wr(2'h2, {3'h0, e1} | 16'h1800);
        wr(2'h3, 16'hFFFF);
        rd(2'h1, d);
        check("mr reg", 19'(d[12:0]), 19'(mr));
        rd(2'h2, d);
        check("emr1 reg", 19'(d[12:0]), 19'(e1));
        rd(2'h3, d);
        check("status idle", 19'(d[4]), 19'h00000);
        @(posedge clk_in);
        #1 check("rdata idle", 19'(rdata_out), 19'h00000);
        wr(2'h0, {14'h0000, skip, 1'b1});
        n = 0;
        while (d[4] !== 1'b1 && n < 3000) begin
            rd(2'h3, d);
            n++;
        end
        if (n >= 3000) begin
            err_total++;
            end_of_test();
        end
        check("status done", 19'(d[4:0]), 19'h0001E);
        check("cke wait", 19'(cke_at >= STABLE), 19'h00001);
        repeat (8) @(posedge clk_in);
        exp_q = {mk(ddr2_init_pkg::CMD_PRECHARGE, 2'h0, 13'h0400),
                 mk(4'h0, ddr2_init_pkg::BANK_EMR2, 13'h0000),
                 mk(4'h0, ddr2_init_pkg::BANK_EMR3, 13'h0000),
                 mk(4'h0, ddr2_init_pkg::BANK_EMR1, e1)};
        if (!skip)
            exp_q.push_back(mk(4'h0, ddr2_init_pkg::BANK_MR, mr | 13'h0100));
        exp_q.push_back(mk(ddr2_init_pkg::CMD_PRECHARGE, 2'h0, 13'h0400));
        exp_q.push_back(mk(ddr2_init_pkg::CMD_REFRESH, 2'h0, 13'h0000));
        exp_q.push_back(mk(ddr2_init_pkg::CMD_REFRESH, 2'h0, 13'h0000));
        exp_q.push_back(mk(4'h0, ddr2_init_pkg::BANK_MR, mr));
        exp_q.push_back(mk(4'h0, ddr2_init_pkg::BANK_EMR1, e1 | 13'h0380));
        exp_q.push_back(mk(4'h0, ddr2_init_pkg::BANK_EMR1, e1));
        check("command count", 19'(seen_q.size()), 19'(exp_q.size()));
        foreach (exp_q[i]) begin
            s = i < seen_q.size() ? seen_q[i] : 19'h7FFFF;
            if (exp_q[i][18:15] == ddr2_init_pkg::CMD_PRECHARGE)
                s &= 19'h78400;
            else if (exp_q[i][18:15] == ddr2_init_pkg::CMD_REFRESH)
                s &= 19'h78000;
            check("link command", s, exp_q[i]);
        end
        check("written", 19'(written_out), 19'h0000F);
        check("mr out", 19'(mr_out), 19'(mr));
        check("emr1 out", 19'(emr1_out), 19'(e1));
        check("emr2 out", 19'(emr2_out), 19'h00000);
        check("cas lat", 19'(cas_lat_out), 19'(mr[6:4]));
        check("dll on", 19'(dll_on_out), 19'h00001);
        check("dqs n", 19'(dqs_n_en_out), 19'(!e1[10]));
        check("read ok", 19'(read_ok_out), 19'h00001);
        check("ready early", 19'(early), 19'h00000);
        burst_check(mr, 1'b0);
        $display("test run_init skip=%0d done", skip);
    endtask : run_init
    task automatic burst_check(input logic [12:0] mr, input logic use_b);
        logic [2:0] e;
        logic [2:0] s;
        for (int c = 0; c < 8; c++) begin
            for (int b = 0; b < (mr[2:0] == ddr2_init_pkg::BL_8 ? 8 : 4);
                 b++) begin
                @(posedge clk_in);
                col_start_in <= 3'(c);
                beat_in      <= 3'(b);
                @(posedge clk_in);
                e = mr[3] ? 3'(c ^ b) : 3'(((c ^ b) & 4) | ((c + b) & 3));
                e[2] = mr[2:0] == ddr2_init_pkg::BL_8 ? e[2] : 1'(c >> 2);
                #1 s = use_b ? b_col : col_out;
                check("burst column", 19'(s), 19'(e));
            end
        end
    endtask : burst_check
    task automatic send_b(input logic k, input logic [1:0] b,
                          input logic [12:0] a);
        @(posedge clk_in);
        link_b.cke <= k;
        {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} <= 4'h0;
        link_b.ba   <= b;
        link_b.addr <= a;
        repeat (4) @(posedge clk_in);
        link_b.ck <= 1'b1;
        repeat (4) @(posedge clk_in);
        link_b.ck <= 1'b0;
        repeat (4) @(posedge clk_in);
        {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} <= 4'hF;
        link_b.addr <= ~a;
        repeat (8) @(posedge clk_in);
    endtask : send_b
    task automatic bad_link;
        send_b(1'b0, ddr2_init_pkg::BANK_EMR2, 13'h0088);
        check("write with cke low", 19'(b_written), 19'h00000);
        send_b(1'b1, ddr2_init_pkg::BANK_EMR3, 13'h0000);
        send_b(1'b1, ddr2_init_pkg::BANK_EMR2, 13'h0088);
        check("emr2 loaded", 19'(b_emr2), 19'h00088);
        check("emr2 flag", 19'(b_written[2]), 19'h00001);
        send_b(1'b1, ddr2_init_pkg::BANK_MR, 13'h0003);
        burst_check(13'h0003, 1'b1);
        $display("test bad_link done");
    endtask : bad_link
    initial begin
        link_b.ck   = 1'b0;
        link_b.cke  = 1'b0;
        {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = 4'hF;
        link_b.ba   = 2'h0;
        link_b.addr = 13'h0000;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        run_init(1'b0, 13'h0A5B, 13'h041E);
        bad_link();
        reset_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        run_init(1'b1, 13'h0442, 13'h0000);
        end_of_test();
    end
endmodule : ddr2_init_mode_registers_bench
